// >>> bench/sct_checker.sv
// port assertions for the tunnel
`timescale 1ns/1ps
module sct_checker
	import sct_pkg::*;
(
	input wire logic clk_i, reset_i, pixel_en_i, frame_sclk_i, frame_ss_n_i, rev_ss_n_i,
	input wire logic fwd_spi_clock_o, fwd_mosi_o, fwd_ss_n_o, bc_frame_req_i,
	input wire logic bc_frame_valid_o, bc_ss_n_o, bc_sample_valid_o,
	input wire logic [2:0] control_channel_mode_field_i
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);
	wire f = control_channel_mode_field_i == MODE_FWD_SPI;
	wire r = control_channel_mode_field_i == MODE_REV_SPI;
	// last forward clock bit taken, models the one pixel lag
	logic d;
	always_ff @(posedge clk_i)
		d <= (reset_i || !f) ? 1'h0 : pixel_en_i ? frame_sclk_i : d;
	ss_fwd_a: assert property (f && pixel_en_i |=> fwd_ss_n_o == $past(frame_ss_n_i))
		else $error("select not rebuilt");
	clk_lag_a: assert property (f && pixel_en_i |=> fwd_spi_clock_o == $past(d))
		else $error("clock lag wrong");
	mosi_hold_a: assert property (f && fwd_spi_clock_o |=> $stable(fwd_mosi_o))
		else $error("mosi moved");
	fwd_off_a: assert property (!f |=> fwd_ss_n_o && !fwd_spi_clock_o && !fwd_mosi_o)
		else $error("forward not idle");
	bc_ans_a: assert property (bc_frame_valid_o == $past(bc_frame_req_i && r && !reset_i))
		else $error("frame answer wrong");
	// three edges from pin to answer: two sync stages, then the answer register
	bc_ss_a: assert property (bc_frame_valid_o |-> bc_ss_n_o == $past(rev_ss_n_i, 3))
		else $error("select state wrong");
	one_smp_a: assert property ($rose(bc_sample_valid_o) |-> bc_frame_valid_o)
		else $error("sample outside frame");
	bc_off_a: assert property (!r |=> bc_ss_n_o && !bc_sample_valid_o && !bc_frame_valid_o)
		else $error("back channel not idle");
endmodule // sct_checker
bind sct_tunnel sct_checker i_sct_checker (
	.clk_i, .reset_i, .pixel_en_i, .frame_sclk_i, .frame_ss_n_i, .rev_ss_n_i,
	.fwd_spi_clock_o, .fwd_mosi_o, .fwd_ss_n_o, .bc_frame_req_i,
	.bc_frame_valid_o, .bc_ss_n_o, .bc_sample_valid_o, .control_channel_mode_field_i
);

// >>> bench/sct_far.sv
// far side spi master model
`timescale 1ns/1ps
module sct_far
	import sct_pkg::*;
(
	input  wire logic clk_i,
	output logic      sclk_o, mosi_o, ss_n_o
);
	initial {sclk_o, mosi_o, ss_n_o} = 3'h1;
	// mode 0 byte; clock stands low outside frames
	task automatic xfer(input logic [7:0] b);
		ss_n_o <= 1'h0;
		for (int i = 7; i >= 0; i--) begin
			mosi_o <= b[i];
			repeat (4) @(posedge clk_i);
			sclk_o <= 1'h1;
			repeat (4) @(posedge clk_i);
			sclk_o <= 1'h0;
		end
		repeat (4) @(posedge clk_i);
		ss_n_o <= 1'h1;
		mosi_o <= ~mosi_o;
		repeat (SS_GAP_5M_CYC) @(posedge clk_i);
	endtask
endmodule // sct_far

// >>> bench/tb_sct_tunnel.sv
// self-checking bench for the tunnel
`timescale 1ns/1ps
module tb_sct_tunnel;
	import sct_pkg::*;
	logic clk_i = 0, reset_i = 1, pixel_en_i = 0, bc_frame_req_i = 0, req_en = 0, ck_q = 0;
	logic [2:0] control_channel_mode_field_i = 3'h0;
	logic frame_sclk_i, frame_mosi_i, frame_ss_n_i, rev_sclk_i, rev_mosi_i, rev_ss_n_i;
	logic fwd_spi_clock_o, fwd_mosi_o, fwd_ss_n_o, bc_frame_valid_o, bc_ss_n_o;
	logic bc_sample_valid_o, bc_sample_o, bc_overflow_o;
	logic [7:0] fr, rr;
	int n = 0, ov = 0, cnt = 0, fail_count = 0, tests_run = 0;
	sct_tunnel #(.DEPTH(4)) i_sct_tunnel (
		.clk_i, .reset_i, .control_channel_mode_field_i,
		.pixel_en_i, .frame_sclk_i, .frame_mosi_i, .frame_ss_n_i,
		.fwd_spi_clock_o, .fwd_mosi_o, .fwd_ss_n_o,
		.rev_sclk_i, .rev_mosi_i, .rev_ss_n_i,
		.bc_frame_req_i, .bc_frame_valid_o, .bc_ss_n_o,
		.bc_sample_valid_o, .bc_sample_o, .bc_overflow_o
	);
	sct_far i_sct_far (.clk_i, .sclk_o(rev_sclk_i), .mosi_o(rev_mosi_i), .ss_n_o(rev_ss_n_i));
	sct_far i_sct_far_f (.clk_i, .sclk_o(frame_sclk_i), .mosi_o(frame_mosi_i),
		.ss_n_o(frame_ss_n_i));
	initial forever #25 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		cnt <= cnt + 1;
		pixel_en_i <= cnt[0];
		bc_frame_req_i <= req_en && cnt[2:0] == 3'h0;
		ck_q <= fwd_spi_clock_o;
		if (fwd_spi_clock_o && !ck_q) fr <= {fr[6:0], fwd_mosi_o};
		if (bc_frame_valid_o && bc_sample_valid_o) begin
			rr <= {rr[6:0], bc_sample_o};
			n <= n + 1;
		end
		if (bc_overflow_o) ov <= ov + 1;
	end
	task chk(input logic ok, input string what);
		tests_run++;
		if (ok !== 1'b1) begin
			fail_count++;
			$display("Error at %0t: %s", $time, what);
		end
	endtask
	task summarize();
		$display("tests %0d, fails %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task t_fwd();
		control_channel_mode_field_i <= MODE_FWD_SPI;
		i_sct_far_f.xfer(8'ha6);
		chk(fr === 8'ha6 && fwd_ss_n_o === 1'h1, "fwd byte");
		$display("forward done");
	endtask
	task t_rev();
		control_channel_mode_field_i <= MODE_REV_SPI;
		req_en <= 1'h1;
		i_sct_far.xfer(8'h5c);
		chk(rr === 8'h5c && n === 8 && bc_ss_n_o === 1'h1, "rev byte");
		$display("reverse done");
	endtask
	// queue of four fills, the other four bits are dropped
	task t_ovf();
		req_en <= 1'h0;
		n = 0;
		i_sct_far.xfer(8'hb3);
		chk(ov === 4, "overflow count");
		req_en <= 1'h1;
		repeat (60) @(posedge clk_i);
		chk(n === 4 && rr[3:0] === 4'hb, "queued bits");
		$display("overflow done");
	endtask
	task t_flush();
		req_en <= 1'h0;
		i_sct_far.xfer(8'hff);
		control_channel_mode_field_i <= 3'h0;
		repeat (2) @(posedge clk_i);
		control_channel_mode_field_i <= MODE_REV_SPI;
		req_en <= 1'h1;
		n = 0;
		repeat (40) @(posedge clk_i);
		chk(n === 0 && fwd_ss_n_o === 1'h1, "queue flushed");
		$display("flush done");
	endtask
	// reset in mid-run returns every output to its idle level
	task t_reset();
		reset_i <= 1'h1;
		repeat (3) @(posedge clk_i);
		chk({fwd_ss_n_o, fwd_spi_clock_o, fwd_mosi_o, bc_ss_n_o} === 4'h9, "reset idle");
		chk({bc_frame_valid_o, bc_sample_valid_o, bc_overflow_o} === 3'h0, "reset quiet");
		reset_i <= 1'h0;
		repeat (20) @(posedge clk_i);
		chk(bc_ss_n_o === 1'h1 && n === 0, "after reset");
		$display("reset done");
	endtask
	initial begin
		repeat (3) @(posedge clk_i);
		reset_i <= 1'h0;
		@(posedge clk_i);
		t_fwd();
		t_rev();
		t_ovf();
		t_flush();
		t_reset();
		summarize();
	end
endmodule // tb_sct_tunnel

// >>> core/sct_tunnel.sv
// spi control channel tunnel, deserializer end
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Contract
// - rebuild spi outputs from forward frame bits
// - mosi output frozen while clock high
// - clock output one pixel behind mosi
// - synchronise select and clock inputs locally
// - capture mosi on synchronised clock edge
// - queue samples, drain into back frames
// - every back frame carries select state
// - at most one sample per back frame
// - read clock period exceeds round trip
// - tunnel never reaches own registers
module sct_tunnel
	import sct_pkg::*;
#(
	parameter int DEPTH = REV_DEPTH
) (
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       reset_i,
	// mode selection
	input  wire logic [2:0] control_channel_mode_field_i,
	// forward frame bits, same clock
	input  wire logic       pixel_en_i,
	input  wire logic       frame_sclk_i,
	input  wire logic       frame_mosi_i,
	input  wire logic       frame_ss_n_i,
	// regenerated spi outputs
	output logic            fwd_spi_clock_o,
	output logic            fwd_mosi_o,
	output logic            fwd_ss_n_o,
	// local spi master pins, asynchronous
	input  wire logic       rev_sclk_i,
	input  wire logic       rev_mosi_i,
	input  wire logic       rev_ss_n_i,
	// back channel framer, same clock
	input  wire logic       bc_frame_req_i,
	output logic            bc_frame_valid_o,
	output logic            bc_ss_n_o,
	output logic            bc_sample_valid_o,
	output logic            bc_sample_o,
	output logic            bc_overflow_o
);

	// one bit wider than an index so a full queue can be counted
	localparam int CW = $clog2(DEPTH + 1);

	typedef struct packed {
		// forward regeneration
		logic             clk_d;
		logic             clk;
		logic             mosi;
		logic             ss_n;
		// reverse pin synchronisers
		logic             ss1;
		logic             ss2;
		logic             ck1;
		logic             ck2;
		logic             ck3;
		logic             mo1;
		logic             mo2;
		// sample queue, head at bit 0
		logic [DEPTH-1:0] qbits;
		logic [CW-1:0]    qcnt;
		// back channel answer
		logic             bc_valid;
		logic             bc_ss_n;
		logic             bc_has;
		logic             bc_data;
		logic             ovf;
	} sct_state_t;

	// every state bit at reset: selects idle high, clocks low, queue empty
	localparam sct_state_t S_RESET = '{
		clk_d:    RST_SCLK,
		clk:      RST_SCLK,
		mosi:     RST_MOSI,
		ss_n:     RST_SS_N,
		ss1:      RST_SS_N,
		ss2:      RST_SS_N,
		ck1:      RST_SCLK,
		ck2:      RST_SCLK,
		ck3:      RST_SCLK,
		mo1:      RST_MOSI,
		mo2:      RST_MOSI,
		qbits:    '0,
		qcnt:     '0,
		bc_valid: 1'h0,
		bc_ss_n:  RST_SS_N,
		bc_has:   1'h0,
		bc_data:  1'h0,
		ovf:      1'h0
	};

	sct_state_t s;
	sct_state_t next_s;

	////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		logic          fwd_on;
		logic          rev_on;
		logic          edge_seen;
		logic          push;
		logic          pop;
		logic [CW-1:0] cnt;
		fwd_on    = (control_channel_mode_field_i == MODE_FWD_SPI);
		rev_on    = (control_channel_mode_field_i == MODE_REV_SPI);
		edge_seen = 1'b0;
		push      = 1'b0;
		pop       = 1'b0;
		cnt       = s.qcnt;
		next_s    = s;

		// pin inputs pass two flops; only the second stage is read
		// a third clock stage keeps the edge detector off the first flop
		next_s.ss1 = rev_ss_n_i;
		next_s.ss2 = s.ss1;
		next_s.ck1 = rev_sclk_i;
		next_s.ck2 = s.ck1;
		next_s.ck3 = s.ck2;
		next_s.mo1 = rev_mosi_i;
		next_s.mo2 = s.mo1;

		// forward regeneration, only frame bits are used: no path to local registers
		// select passes straight through; only mosi needs a hold window
		// deselect parks the forward outputs at their idle levels
		if (!fwd_on) begin
			next_s.clk_d = RST_SCLK;
			next_s.clk   = RST_SCLK;
			next_s.mosi  = RST_MOSI;
			next_s.ss_n  = RST_SS_N;
		end else if (pixel_en_i) begin
			next_s.clk_d = frame_sclk_i;
			next_s.clk   = s.clk_d;
			next_s.ss_n  = frame_ss_n_i;
			// mosi moves only when the clock out is low now and next
			if (!s.clk && !s.clk_d) begin
				next_s.mosi = frame_mosi_i;
			end
		end

		// reverse capture on the rising synchronised clock edge
		// the slave shifts on the falling edge, so rising is the safe capture edge
		edge_seen   = s.ck2 && !s.ck3;
		push        = rev_on && !s.ss2 && edge_seen;
		pop         = rev_on && bc_frame_req_i && (s.qcnt != '0);
		// one-cycle pulses rest low
		next_s.ovf  = 1'b0;
		next_s.bc_valid = 1'b0;

		// every answer reports select, even with an empty queue
		if (rev_on && bc_frame_req_i) begin
			next_s.bc_valid = 1'b1;
			next_s.bc_ss_n  = s.ss2;
			next_s.bc_has   = pop;
			next_s.bc_data  = s.qbits[0];
		end

		// queue: head at bit 0, shift out on pop, append at count
		// pop first, so a full queue still takes a bit in a drain cycle
		if (pop) begin
			next_s.qbits = s.qbits >> 1;
			cnt          = s.qcnt - CW'(1);
		end
		if (push) begin
			if (cnt < CW'(DEPTH)) begin
				next_s.qbits[cnt[$clog2(DEPTH)-1:0]] = s.mo2;
				cnt = cnt + CW'(1);
			end else begin
				// full queue drops the newest bit; the master must pace reads
				next_s.ovf = 1'b1;
			end
		end
		next_s.qcnt = cnt;

		// flushing on deselect keeps stale bits out of a later access
		if (!rev_on) begin
			next_s.qbits   = '0;
			next_s.qcnt    = '0;
			next_s.bc_ss_n = RST_SS_N;
			next_s.bc_has  = 1'b0;
			next_s.bc_data = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// state register

	// synchronous reset loads the whole state in one step
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			s <= S_RESET;
		end else begin
			s <= next_s;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs, all straight from the state register
	// nothing is decoded on the way out, so no output can glitch

	assign fwd_spi_clock_o   = s.clk;
	assign fwd_mosi_o        = s.mosi;
	assign fwd_ss_n_o        = s.ss_n;
	assign bc_frame_valid_o  = s.bc_valid;
	assign bc_ss_n_o         = s.bc_ss_n;
	assign bc_sample_valid_o = s.bc_has;
	assign bc_sample_o       = s.bc_data;
	assign bc_overflow_o     = s.ovf;

endmodule // sct_tunnel

// >>> pkg/sct_pkg.sv
// constants shared by the spi control channel tunnel
package sct_pkg;

	// control_channel_mode_field encodings
	localparam logic [2:0] MODE_FWD_SPI  = 3'h6;
	localparam logic [2:0] MODE_REV_SPI  = 3'h7;

	// reset values of the regenerated spi outputs
	localparam logic       RST_SS_N      = 1'h1;
	localparam logic       RST_SCLK      = 1'h0;
	localparam logic       RST_MOSI      = 1'h0;

	// default depth of the reverse sample queue
	localparam int         REV_DEPTH     = 16;

	// clock rate and least slave-select gap per back-channel rate
	localparam int         CLK_HZ        = 20_000_000;
	localparam real        SS_GAP_5M_US  = 7.5;
	localparam real        SS_GAP_10M_US = 3.75;
	localparam real        SS_GAP_20M_US = 1.875;
	localparam int         SS_GAP_5M_CYC  = int'($ceil(SS_GAP_5M_US * CLK_HZ / 1.0e6));
	localparam int         SS_GAP_10M_CYC = int'($ceil(SS_GAP_10M_US * CLK_HZ / 1.0e6));
	localparam int         SS_GAP_20M_CYC = int'($ceil(SS_GAP_20M_US * CLK_HZ / 1.0e6));

endpackage
